//--- pkg/cil_pkg.sv
// Constants shared by the cascaded interrupt input logic
package cil_pkg;
    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_ENABLE = 8'h00;
    localparam logic [7:0] ADDR_MODE   = 8'h04;
    localparam logic [7:0] ADDR_PEND   = 8'h08;
    localparam logic [7:0] ADDR_VBASE  = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    // ----------------------------------------------------------------
    // Reset values and field positions
    // ----------------------------------------------------------------
    localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
    localparam logic [31:0] RST_MODE   = 32'h0000_0000;
    localparam logic [31:0] RST_VBASE  = 32'h0000_0010;
    localparam int          STAT_SEL_LSB  = 0;
    localparam int          STAT_ANY_BIT  = 5;
    localparam int          STAT_ROLE_LSB = 6;

    // ----------------------------------------------------------------
    // Positions and roles
    // ----------------------------------------------------------------
    localparam int MAX_SOURCES = 32;
    localparam int CASC_POS    = 31;

    typedef enum logic [2:0] {
        ROLE_FINAL   = 3'b001,
        ROLE_INTER   = 3'b010,
        ROLE_PRIMARY = 3'b100
    } cil_role_t;
endpackage

//--- design/cil_top.sv
// Cascade and input recognition logic of the interrupt controller
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
//
// Contract
// - One instance takes at most 32 sources; larger systems chain instances.
// - Cascade disabled with primary set is illegal, refused at elaboration.
// - Both cascade settings set: primary instance, talks to processor.
// - Primary offers 31 peripheral inputs; position 31 is the cascade port.
// - Cascade set, primary clear: intermediate stage for over 63 sources.
// - Intermediate has a cascade port and 31 peripheral inputs.
// - Both settings clear: final instance, no cascade port, 1 to 32 inputs.
// - Cascade port bundles request in, vector in and acknowledge out.
// - Positions 0 to 30 are serviced before cascaded position 31.
// - Standard mode cascade adds only the request input.
// - Fast mode cascade adds request, vector input and acknowledge output.
// - Fast mode drives handler address out; processor acknowledges it.
module cil_top #(
    parameter int          NUM_INPUTS      = 32,
    parameter bit          EN_CASCADE      = 1'b0,
    parameter bit          CASCADE_PRIMARY = 1'b0,
    parameter bit          HAS_FAST        = 1'b0,
    parameter logic [31:0] REQUEST_EDGE_OR_LEVEL_SETTING  = 32'hffff_ffff,
    parameter logic [31:0] REQUEST_ASYNC_SAMPLING_SETTING = 32'h0000_0000
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [NUM_INPUTS-1:0] intr,
    input  wire logic                  irq_in,
    input  wire logic [31:0]           vec_in,
    output logic                       ack_out,
    output logic                       irq,
    output logic      [31:0]           vector_addr,
    input  wire logic                  proc_ack
);
    // ----------------------------------------------------------------
    // Configuration checks
    // ----------------------------------------------------------------
    if (NUM_INPUTS < 1 || NUM_INPUTS > cil_pkg::MAX_SOURCES) begin : g_bad_num
        $error("input count must be 1 to 32");
    end
    if (!EN_CASCADE && CASCADE_PRIMARY) begin : g_bad_casc
        $error("primary set without cascade enable");
    end

    // Role follows the two cascade settings
    localparam cil_pkg::cil_role_t ROLE = !EN_CASCADE ? cil_pkg::ROLE_FINAL :
        (CASCADE_PRIMARY ? cil_pkg::ROLE_PRIMARY : cil_pkg::ROLE_INTER);

    // ----------------------------------------------------------------
    // Input sampling
    // ----------------------------------------------------------------
    logic [31:0] raw;
    logic [31:0] sync1_r;
    logic [31:0] sync2_r;
    logic [31:0] sync3_r;
    logic [31:0] samp_r;
    logic [31:0] samp_nxt;
    logic [31:0] prev_r;

    // Unused positions read as zero
    always_comb begin
        raw = '0;
        raw[NUM_INPUTS-1:0] = intr;
    end

    // Per bit: async passes three flops, sync is taken directly
    for (genvar i = 0; i < 32; i++) begin : g_samp
        always_comb begin
            if (REQUEST_ASYNC_SAMPLING_SETTING[i]) begin
                samp_nxt[i] = (sync2_r[i] == sync3_r[i]) ? sync3_r[i] : samp_r[i];
            end else begin
                samp_nxt[i] = raw[i];
            end
        end
    end

    // Synchroniser and sample registers
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
            samp_r  <= '0;
            prev_r  <= '0;
        end else begin
            sync1_r <= raw;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            samp_r  <= samp_nxt;
            prev_r  <= samp_r;
        end
    end

    // ----------------------------------------------------------------
    // Registers, pending and service state
    // ----------------------------------------------------------------
    logic [31:0] enable_r;
    logic [31:0] enable_nxt;
    logic [31:0] mode_r;
    logic [31:0] mode_nxt;
    logic [31:0] vbase_r;
    logic [31:0] vbase_nxt;
    logic [31:0] pend_r;
    logic [31:0] pend_nxt;
    logic [31:0] req;
    logic [31:0] clr;
    logic [4:0]  sel;
    logic        any;
    logic        fast_sel;
    logic        casc_sel;
    logic        irq_nxt;
    logic        ack_out_nxt;
    logic [31:0] vector_nxt;
    logic        wr;

    assign wr = psel && penable && pwrite;

    // Request per position: level follows input, edge is latched
    always_comb begin
        req = '0;
        clr = '0;
        pend_nxt = '0;
        for (int i = 0; i < 32; i++) begin
            if (wr && paddr == cil_pkg::ADDR_PEND) begin
                clr[i] = pwdata[i];
            end
            if (proc_ack && any && sel == i[4:0]) begin
                clr[i] = 1'b1;
            end
            if (EN_CASCADE && i == cil_pkg::CASC_POS) begin
                req[i] = irq_in;
            end else if (i < NUM_INPUTS) begin
                if (REQUEST_EDGE_OR_LEVEL_SETTING[i]) begin
                    // Set wins over a clear in the same cycle
                    pend_nxt[i] = (samp_r[i] && !prev_r[i]) ||
                        (pend_r[i] && !clr[i]);
                    req[i] = pend_r[i];
                end else begin
                    req[i] = samp_r[i];
                end
            end
        end
    end

    // Lowest index wins, so position 31 comes last
    always_comb begin
        sel = 5'h00;
        any = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            if (req[i] && enable_r[i]) begin
                sel = i[4:0];
                any = 1'b1;
            end
        end
    end

    assign casc_sel = EN_CASCADE && any && sel == 5'(cil_pkg::CASC_POS);
    assign fast_sel = HAS_FAST && any && mode_r[sel];

    // Next values of software registers and outputs
    always_comb begin
        enable_nxt  = enable_r;
        mode_nxt    = mode_r;
        vbase_nxt   = vbase_r;
        if (wr && paddr == cil_pkg::ADDR_ENABLE) begin
            enable_nxt = pwdata;
        end
        if (wr && paddr == cil_pkg::ADDR_MODE && HAS_FAST) begin
            mode_nxt = pwdata;
        end
        if (wr && paddr == cil_pkg::ADDR_VBASE) begin
            vbase_nxt = pwdata;
        end
        irq_nxt     = any;
        vector_nxt  = vbase_r;
        if (fast_sel) begin
            vector_nxt = casc_sel ? vec_in :
                vbase_r + {25'h0000000, sel, 2'b00};
        end
        ack_out_nxt = proc_ack && fast_sel && casc_sel;
    end

    // Register update
    always_ff @(posedge clk) begin
        if (rst) begin
            enable_r    <= cil_pkg::RST_ENABLE;
            mode_r      <= cil_pkg::RST_MODE;
            vbase_r     <= cil_pkg::RST_VBASE;
            pend_r      <= '0;
            irq         <= 1'b0;
            vector_addr <= cil_pkg::RST_VBASE;
            ack_out     <= 1'b0;
        end else begin
            enable_r    <= enable_nxt;
            mode_r      <= mode_nxt;
            vbase_r     <= vbase_nxt;
            pend_r      <= pend_nxt;
            irq         <= irq_nxt;
            vector_addr <= vector_nxt;
            ack_out     <= ack_out_nxt;
        end
    end

    // ----------------------------------------------------------------
    // APB slave, zero wait states
    // ----------------------------------------------------------------
    logic [31:0] rd_nxt;
    logic        hit;

    // Decode and read mux, sampled in the setup cycle
    always_comb begin
        hit    = 1'b1;
        rd_nxt = '0;
        case (paddr)
            cil_pkg::ADDR_ENABLE: rd_nxt = enable_r;
            cil_pkg::ADDR_MODE:   rd_nxt = HAS_FAST ? mode_r : 32'h0000_0000;
            cil_pkg::ADDR_PEND:   rd_nxt = req;
            cil_pkg::ADDR_VBASE:  rd_nxt = vbase_r;
            cil_pkg::ADDR_STATUS: begin
                rd_nxt[cil_pkg::STAT_SEL_LSB +: 5]  = sel;
                rd_nxt[cil_pkg::STAT_ANY_BIT]       = any;
                rd_nxt[cil_pkg::STAT_ROLE_LSB +: 3] = ROLE;
            end
            default: hit = 1'b0;
        endcase
    end

    // Read data register
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_nxt;
        end
    end

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    AST_PRIO_LOW_FIRST: assert property (@(posedge clk) disable iff (rst)
        |(req[30:0] & enable_r[30:0]) |-> sel != 5'd31)
        else $error("position 31 chosen over a lower request");

    AST_CASC_SOURCE: assert property (@(posedge clk) disable iff (rst)
        EN_CASCADE |-> req[31] == irq_in)
        else $error("cascade position not fed by request input");

    AST_INTR31_UNUSED: assert property (@(posedge clk) disable iff (rst)
        (EN_CASCADE && raw[31] && !irq_in) |-> !req[31])
        else $error("peripheral input 31 reached the cascade position");

    AST_CASC_VECTOR: assert property (@(posedge clk) disable iff (rst)
        (fast_sel && casc_sel) |=> vector_addr == $past(vec_in))
        else $error("downstream vector not forwarded");

    AST_ACK_FORWARD: assert property (@(posedge clk) disable iff (rst)
        (proc_ack && fast_sel && casc_sel) |=> ack_out ##1 !ack_out || $past(proc_ack))
        else $error("acknowledge not forwarded downstream");

    AST_STD_NO_ACK: assert property (@(posedge clk) disable iff (rst)
        !fast_sel |=> !ack_out)
        else $error("acknowledge out driven in standard mode");

    AST_FAST_VECTOR: assert property (@(posedge clk) disable iff (rst)
        (fast_sel && !casc_sel) |=>
        vector_addr == $past(vbase_r) + {25'h0000000, $past(sel), 2'b00})
        else $error("handler address wrong");

    AST_EDGE_LATCH: assert property (@(posedge clk) disable iff (rst)
        (REQUEST_EDGE_OR_LEVEL_SETTING[0] && samp_r[0] && !prev_r[0]) |=> pend_r[0])
        else $error("edge not latched");

    AST_SYNC_AGREE: assert property (@(posedge clk) disable iff (rst)
        (REQUEST_ASYNC_SAMPLING_SETTING[2] && samp_r[2] != $past(samp_r[2])) |->
        $past(sync2_r[2]) == $past(sync3_r[2]))
        else $error("async input changed before stages agreed");

    AST_IRQ_FOLLOWS: assert property (@(posedge clk) disable iff (rst)
        any |=> irq)
        else $error("irq missing after request");
endmodule

//--- verification/cil_far_model.sv
// Far-side model: downstream stage and processor acknowledge
`timescale 1ns/1ps
module cil_far_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        req_go,
    input  wire logic [31:0] req_vec,
    input  wire logic        ack_go,
    input  wire logic        ack_out,
    output logic             irq_in,
    output logic      [31:0] vec_in,
    output logic             proc_ack
);
    logic req_d;
    logic ack_d;
    logic irq_nxt;

    // Request held until acknowledged; vector scrambled while idle
    always @(posedge clk) begin
        irq_nxt = irq_in;
        if (ack_out) irq_nxt = 1'b0;
        if (req_go && !req_d) irq_nxt = 1'b1;
        if (rst) irq_nxt = 1'b0;
        req_d    <= req_go;
        ack_d    <= ack_go;
        irq_in   <= irq_nxt;
        vec_in   <= rst ? 32'h0 : (irq_nxt ? req_vec : ~vec_in);
        proc_ack <= ack_go && !ack_d && !rst;
    end
endmodule

//--- verification/cil_top_tb.sv
// Self-checking bench for the cascade and input logic
`timescale 1ns/1ps
module cil_top_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] intr = 32'h0;
    logic        req_go = 1'b0;
    logic        ack_go = 1'b0;
    logic [31:0] req_vec = 32'h0;
    logic [31:0] prdata, vec_in, vector_addr, rd;
    logic        pready, pslverr, irq_in, ack_out, irq, proc_ack, er;
    int          n_tests = 0;
    int          n_fail = 0;
    localparam logic [31:0] VB = cil_pkg::RST_VBASE;

    // Clock
    always #10 clk = ~clk;

    cil_top #(.EN_CASCADE(1'b1), .CASCADE_PRIMARY(1'b1), .HAS_FAST(1'b1),
        .REQUEST_EDGE_OR_LEVEL_SETTING(32'h0000_0005),
        .REQUEST_ASYNC_SAMPLING_SETTING(32'h0000_000c)) cil_top_i (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .intr(intr), .irq_in(irq_in), .vec_in(vec_in),
        .ack_out(ack_out), .irq(irq), .vector_addr(vector_addr), .proc_ack(proc_ack));

    cil_far_model cil_far_model_i (.clk(clk), .rst(rst), .req_go(req_go), .req_vec(req_vec),
        .ack_go(ack_go), .ack_out(ack_out), .irq_in(irq_in), .vec_in(vec_in),
        .proc_ack(proc_ack));

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] pick(input int s);
        return (s == 0) ? {31'h0, irq} : (s == 1) ? vector_addr : {31'h0, ack_out};
    endfunction

    task automatic wait_for(input string nm, input int s, input logic [31:0] ex);
        int k;
        k = 0;
        while (pick(s) !== ex && k < 20) begin
            @(posedge clk);
            k++;
        end
        chk(nm, ex, pick(s));
    endtask

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_regs;
        apb(1'b0, cil_pkg::ADDR_ENABLE, 32'h0);
        chk("enable", cil_pkg::RST_ENABLE, rd);
        apb(1'b0, cil_pkg::ADDR_VBASE, 32'h0);
        chk("vbase", VB, rd);
        apb(1'b0, cil_pkg::ADDR_STATUS, 32'h0);
        chk("role", {23'h0, cil_pkg::ROLE_PRIMARY, 6'h00}, rd);
        apb(1'b1, 8'h14, 32'hffff_ffff);
        chk("pslverr", 32'h1, {31'h0, er});
        apb(1'b1, cil_pkg::ADDR_ENABLE, 32'hffff_ffff);
        apb(1'b1, cil_pkg::ADDR_MODE, 32'hffff_ffff);
        apb(1'b0, cil_pkg::ADDR_MODE, 32'h0);
        chk("mode", 32'hffff_ffff, rd);
        $display("test regs done");
    endtask

    task automatic t_edges;
        intr[0] <= 1'b1;
        @(posedge clk);
        intr[0] <= 1'b0;
        wait_for("irq sync edge", 0, 32'h1);
        wait_for("vector 0", 1, VB);
        repeat (3) @(posedge clk);
        chk("edge held", 32'h1, {31'h0, irq});
        apb(1'b0, cil_pkg::ADDR_PEND, 32'h0);
        chk("pending", 32'h1, rd);
        apb(1'b1, cil_pkg::ADDR_PEND, 32'h1);
        wait_for("irq clear", 0, 32'h0);
        intr[2] <= 1'b1;
        repeat (2) @(posedge clk);
        intr[2] <= 1'b0;
        wait_for("irq async edge", 0, 32'h1);
        wait_for("vector 2", 1, VB + 32'h8);
        apb(1'b1, cil_pkg::ADDR_PEND, 32'h4);
        wait_for("irq clear 2", 0, 32'h0);
        $display("test edges done");
    endtask

    task automatic t_levels;
        apb(1'b1, cil_pkg::ADDR_MODE, 32'h0);
        apb(1'b1, cil_pkg::ADDR_VBASE, 32'h0000_0100);
        intr[1] <= 1'b1;
        @(posedge clk);
        intr[1] <= 1'b0;
        wait_for("irq sync level", 0, 32'h1);
        chk("vector normal", 32'h0000_0100, vector_addr);
        wait_for("irq level drop", 0, 32'h0);
        intr[3] <= 1'b1;
        repeat (2) @(posedge clk);
        intr[3] <= 1'b0;
        wait_for("irq async level", 0, 32'h1);
        wait_for("irq level drop 2", 0, 32'h0);
        apb(1'b1, cil_pkg::ADDR_MODE, 32'hffff_ffff);
        apb(1'b1, cil_pkg::ADDR_VBASE, VB);
        $display("test levels done");
    endtask

    task automatic t_cascade;
        req_vec <= 32'h0000_a5c0;
        req_go <= 1'b1;
        intr[1] <= 1'b1;
        wait_for("vector 1", 1, VB + 32'h4);
        apb(1'b0, cil_pkg::ADDR_STATUS, 32'h0);
        chk("sel 1", {23'h0, cil_pkg::ROLE_PRIMARY, 1'b1, 5'h01}, rd);
        intr[1] <= 1'b0;
        wait_for("vector fwd", 1, 32'h0000_a5c0);
        apb(1'b0, cil_pkg::ADDR_STATUS, 32'h0);
        chk("sel 31", {23'h0, cil_pkg::ROLE_PRIMARY, 1'b1, 5'h1f}, rd);
        ack_go <= 1'b1;
        wait_for("ack out", 2, 32'h1);
        @(posedge clk);
        chk("ack pulse", 32'h0, {31'h0, ack_out});
        wait_for("irq cascade clear", 0, 32'h0);
        req_go <= 1'b0;
        ack_go <= 1'b0;
        intr[31] <= 1'b1;
        repeat (8) @(posedge clk);
        chk("intr31 ignored", 32'h0, {31'h0, irq});
        intr[31] <= 1'b0;
        $display("test cascade done");
    endtask

    // --------------------------------------------------------------
    // Run control
    // --------------------------------------------------------------
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_edges;
        t_levels;
        t_cascade;
        finish_test;
    end

    // Watchdog
    initial begin
        #(20 * 5000);
        n_fail++;
        finish_test;
    end
endmodule
